// [common/prescaler_pkg.sv]
package prescaler_pkg;

    // ----------------------------------------------------------------
    // Chain sizes and bus widths
    // ----------------------------------------------------------------
    localparam int HIGH_STAGES = 8;
    localparam int LOW_STAGES = 15;
    localparam int AXI_AW = 8;
    localparam int AXI_DW = 32;
    localparam int WARMUP_DEFAULT = 32768;
    localparam int WARM_CNT_W = 16;

    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [AXI_AW-1:0] SYS_CLOCK_ADDR = 8'h00;
    localparam logic [AXI_AW-1:0] DIV_CTRL_ADDR = 8'h04;
    localparam logic [AXI_AW-1:0] TRIM_A_ADDR = 8'h08;
    localparam logic [AXI_AW-1:0] TRIM_B_ADDR = 8'h0C;
    localparam logic [AXI_AW-1:0] CHAIN_ADDR = 8'h10;

    // ----------------------------------------------------------------
    // Field positions and reset values
    // ----------------------------------------------------------------
    localparam int RC_ON_BIT = 0;
    localparam int EXT_SEL_BIT = 1;
    localparam int XTAL_ON_BIT = 2;
    localparam int CORE_SEL_BIT = 3;
    localparam int CLEAR_BIT = 0;
    localparam int WARM_BIT = 1;
    localparam int RANGE_BIT = 4;
    localparam int LOW_CHAIN_LSB = 8;
    localparam logic [3:0] COARSE_RST = 4'h1;
    localparam logic [5:0] FINE_RST = 6'h00;
    localparam logic RANGE_RST = 1'b0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ----------------------------------------------------------------
    // Tap decoder: {last index of row, log2 of divide ratio}
    // ----------------------------------------------------------------
    localparam int DEC_ROWS = 51;
    localparam logic [10:0] DEC_TABLE [DEC_ROWS] = '{
        {8'h04, 3'h0}, {8'h0C, 3'h1}, {8'h0F, 3'h2}, {8'h10, 3'h1},
        {8'h16, 3'h2}, {8'h17, 3'h3}, {8'h1C, 3'h2}, {8'h1F, 3'h3},
        {8'h22, 3'h2}, {8'h27, 3'h3}, {8'h28, 3'h2}, {8'h2E, 3'h3},
        {8'h2F, 3'h4}, {8'h35, 3'h3}, {8'h37, 3'h4}, {8'h3C, 3'h3},
        {8'h3F, 3'h4}, {8'h43, 3'h3}, {8'h47, 3'h4}, {8'h4A, 3'h3},
        {8'h4F, 3'h4}, {8'h51, 3'h3}, {8'h57, 3'h4}, {8'h58, 3'h3},
        {8'h5E, 3'h4}, {8'h5F, 3'h5}, {8'h66, 3'h4}, {8'h67, 3'h5},
        {8'h6D, 3'h4}, {8'h6F, 3'h5}, {8'h74, 3'h4}, {8'h77, 3'h5},
        {8'h7C, 3'h4}, {8'h7F, 3'h5}, {8'h82, 3'h3}, {8'h8A, 3'h4},
        {8'h94, 3'h5}, {8'h97, 3'h6}, {8'h9A, 3'h5}, {8'h9F, 3'h6},
        {8'hA3, 3'h5}, {8'hAC, 3'h6}, {8'hAF, 3'h7}, {8'hB3, 3'h6},
        {8'hB7, 3'h7}, {8'hBA, 3'h6}, {8'hBF, 3'h7}, {8'hC1, 3'h6},
        {8'hC7, 3'h7}, {8'hC8, 3'h6}, {8'hFF, 3'h7}
    };

    // ----------------------------------------------------------------
    // Whole state of the block
    // ----------------------------------------------------------------
    typedef struct packed {
        logic rc_osc_on;
        logic external_clock_select;
        logic crystal_osc_on;
        logic core_clock_select;
        logic [5:0] osc_trim_fine;
        logic [3:0] osc_trim_coarse;
        logic osc_trim_range;
        logic ext_prev;
        logic ext_half;
        logic hp_lvl;
        logic [HIGH_STAGES-1:0] hp_cnt;
        logic xtal_prev;
        logic src_xtal;
        logic [2:0] src_tap;
        logic lp_lvl;
        logic [LOW_STAGES-1:0] lp_cnt;
        logic crystal_warmup_flag;
        logic [WARM_CNT_W-1:0] warm_cnt;
        logic core_clk;
        logic awready;
        logic wready;
        logic aw_ok;
        logic w_ok;
        logic [AXI_AW-1:0] awaddr;
        logic [AXI_DW-1:0] wdata;
        logic wstrb0;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [AXI_DW-1:0] rdata;
        logic [1:0] rresp;
    } state_s;

endpackage

// [rtl/prescaler_32k_tap_select.sv]
// Chosen here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Function
// - High chain eight stages, low chain fifteen.
// - High chain from RC or external only.
// - Low input is crystal if crystal on and external not selected.
// - Clear bit resets low chain synchronously.
// - Crystal enable set clears low chain.
// - Global reset clears both chains.
// - Warmup flag high for 32768 crystal cycles.
// - Decoder picks tap nearest 32 kHz.
// - Index is range, coarse, fine top bits.
// - Low indices select undivided or half.
// - Next indices select divide by 2/4/8.
// - Following indices select divide by 4/8.
// - Middle indices select divide by 8/16.
// - Upper indices select divide by 16/32.
// - Range set low rows select divide by 8/16/32.
// - Top indices select divide by 128.
// - External clock halved before internal use.
// - Core slow clock from crystal or tap.
module prescaler_32k_tap_select
    import prescaler_pkg::*;
#(
    parameter int WARMUP_CYCLES = WARMUP_DEFAULT
) (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RESET_N,
    // Oscillator levels
    input wire logic RC_CLK,
    input wire logic XTAL_CLK,
    input wire logic EXT_CLK,
    // Divider outputs
    output logic [HIGH_STAGES-1:0] HIGH_DIV_OUT,
    output logic [LOW_STAGES-1:0] LOW_DIV_OUT,
    output logic LOW_DIV_IN,
    output logic CORE_SLOW_CLK,
    output logic WARMUP_FLAG,
    // AXI4-Lite write channels
    input wire logic [AXI_AW-1:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [AXI_DW-1:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    // AXI4-Lite read channels
    input wire logic [AXI_AW-1:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [AXI_DW-1:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [2:0] tap_of(input logic [7:0] idx);
        logic [2:0] t;
        logic hit;
        t = '0;
        hit = 1'b0;
        for (int i = 0; i < DEC_ROWS; i++) begin
            if (!hit && idx <= DEC_TABLE[i][10:3]) begin
                t = DEC_TABLE[i][2:0];
                hit = 1'b1;
            end
        end
        return t;
    endfunction

    function automatic logic tap_lvl(input logic [2:0] k, input state_s s);
        logic v;
        v = s.hp_lvl;
        if (k != 3'h0) begin
            v = s.hp_cnt[k - 3'h1];
        end
        return v;
    endfunction

    state_s s_ff;
    state_s nxt_s;
    logic [7:0] idx;
    logic [2:0] cand_tap;
    logic cand_xtal;
    logic cand_lvl;
    logic cur_lvl;
    logic hp_run;
    logic hp_new;
    logic xtal_rise;
    logic wr_go;
    logic wr_hit;
    logic clr_low;
    logic xtal_set;
    logic [AXI_DW-1:0] rd;
    logic rd_hit;

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        nxt_s = s_ff;
        clr_low = 1'b0;
        xtal_set = 1'b0;
        wr_hit = 1'b1;
        rd = '0;
        rd_hit = 1'b1;

        // Register writes take effect when address and data are both held.
        wr_go = s_ff.aw_ok && s_ff.w_ok && !s_ff.bvalid;
        if (wr_go) begin
            unique case (s_ff.awaddr)
                SYS_CLOCK_ADDR: begin
                    if (s_ff.wstrb0) begin
                        nxt_s.rc_osc_on = s_ff.wdata[RC_ON_BIT];
                        nxt_s.external_clock_select = s_ff.wdata[EXT_SEL_BIT];
                        nxt_s.crystal_osc_on = s_ff.wdata[XTAL_ON_BIT];
                        nxt_s.core_clock_select = s_ff.wdata[CORE_SEL_BIT];
                        xtal_set = s_ff.wdata[XTAL_ON_BIT] && !s_ff.crystal_osc_on;
                    end
                end
                DIV_CTRL_ADDR: begin
                    clr_low = s_ff.wstrb0 && s_ff.wdata[CLEAR_BIT];
                end
                TRIM_A_ADDR: begin
                    if (s_ff.wstrb0) begin
                        nxt_s.osc_trim_fine = s_ff.wdata[5:0];
                    end
                end
                TRIM_B_ADDR: begin
                    if (s_ff.wstrb0) begin
                        nxt_s.osc_trim_coarse = s_ff.wdata[3:0];
                        nxt_s.osc_trim_range = s_ff.wdata[RANGE_BIT];
                    end
                end
                CHAIN_ADDR: begin
                    wr_hit = 1'b1;
                end
                default: begin
                    wr_hit = 1'b0;
                end
            endcase
        end

        // External clock is halved before anything else sees it.
        if (EXT_CLK && !s_ff.ext_prev) begin
            nxt_s.ext_half = !s_ff.ext_half;
        end
        nxt_s.ext_prev = EXT_CLK;

        // High chain input and count.
        hp_run = s_ff.rc_osc_on || s_ff.external_clock_select;
        hp_new = 1'b0;
        if (hp_run) begin
            hp_new = s_ff.external_clock_select ? s_ff.ext_half : RC_CLK;
        end
        nxt_s.hp_lvl = hp_new;
        if (hp_new && !s_ff.hp_lvl) begin
            nxt_s.hp_cnt = s_ff.hp_cnt + 8'h01;
        end

        // Tap decode and low chain source choice.
        idx = {s_ff.osc_trim_range, s_ff.osc_trim_coarse, s_ff.osc_trim_fine[5:3]};
        cand_tap = tap_of(idx);
        cand_xtal = s_ff.crystal_osc_on && !s_ff.external_clock_select;
        cand_lvl = cand_xtal ? XTAL_CLK : tap_lvl(cand_tap, s_ff);
        cur_lvl = s_ff.src_xtal ? XTAL_CLK : tap_lvl(s_ff.src_tap, s_ff);

        // Sources only swap while both the old and the new level are low.
        if (!s_ff.lp_lvl && !cur_lvl && !cand_lvl) begin
            nxt_s.src_xtal = cand_xtal;
            nxt_s.src_tap = cand_tap;
        end
        nxt_s.lp_lvl = cur_lvl;
        if (clr_low || xtal_set) begin
            nxt_s.lp_cnt = '0;
        end else if (cur_lvl && !s_ff.lp_lvl) begin
            nxt_s.lp_cnt = s_ff.lp_cnt + 15'h0001;
        end

        // Crystal warmup tracking.
        xtal_rise = XTAL_CLK && !s_ff.xtal_prev;
        nxt_s.xtal_prev = XTAL_CLK;
        if (xtal_set) begin
            nxt_s.crystal_warmup_flag = 1'b1;
            nxt_s.warm_cnt = '0;
        end else if (!s_ff.crystal_osc_on) begin
            nxt_s.crystal_warmup_flag = 1'b0;
        end else if (s_ff.crystal_warmup_flag && xtal_rise) begin
            nxt_s.warm_cnt = s_ff.warm_cnt + 16'h0001;
            if (s_ff.warm_cnt == WARM_CNT_W'(WARMUP_CYCLES - 1)) begin
                nxt_s.crystal_warmup_flag = 1'b0;
            end
        end

        // Slow core clock.
        nxt_s.core_clk = 1'b0;
        if (s_ff.core_clock_select) begin
            nxt_s.core_clk = cand_xtal ? XTAL_CLK : tap_lvl(cand_tap, s_ff);
        end

        // Write channel handshakes.
        if (s_ff.awready && S_AXI_AWVALID) begin
            nxt_s.awready = 1'b0;
            nxt_s.aw_ok = 1'b1;
            nxt_s.awaddr = S_AXI_AWADDR;
        end
        if (s_ff.wready && S_AXI_WVALID) begin
            nxt_s.wready = 1'b0;
            nxt_s.w_ok = 1'b1;
            nxt_s.wdata = S_AXI_WDATA;
            nxt_s.wstrb0 = S_AXI_WSTRB[0];
        end
        if (wr_go) begin
            nxt_s.bvalid = 1'b1;
            nxt_s.bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
        end
        if (s_ff.bvalid && S_AXI_BREADY) begin
            nxt_s.bvalid = 1'b0;
            nxt_s.aw_ok = 1'b0;
            nxt_s.w_ok = 1'b0;
            nxt_s.awready = 1'b1;
            nxt_s.wready = 1'b1;
        end

        // Read channel.
        unique case (S_AXI_ARADDR)
            SYS_CLOCK_ADDR: begin
                rd[RC_ON_BIT] = s_ff.rc_osc_on;
                rd[EXT_SEL_BIT] = s_ff.external_clock_select;
                rd[XTAL_ON_BIT] = s_ff.crystal_osc_on;
                rd[CORE_SEL_BIT] = s_ff.core_clock_select;
            end
            DIV_CTRL_ADDR: begin
                rd[WARM_BIT] = s_ff.crystal_warmup_flag;
            end
            TRIM_A_ADDR: begin
                rd[5:0] = s_ff.osc_trim_fine;
            end
            TRIM_B_ADDR: begin
                rd[3:0] = s_ff.osc_trim_coarse;
                rd[RANGE_BIT] = s_ff.osc_trim_range;
            end
            CHAIN_ADDR: begin
                rd[HIGH_STAGES-1:0] = s_ff.hp_cnt;
                rd[LOW_CHAIN_LSB +: LOW_STAGES] = s_ff.lp_cnt;
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
        if (s_ff.arready && S_AXI_ARVALID) begin
            nxt_s.arready = 1'b0;
            nxt_s.rvalid = 1'b1;
            nxt_s.rdata = rd;
            nxt_s.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
        if (s_ff.rvalid && S_AXI_RREADY) begin
            nxt_s.rvalid = 1'b0;
            nxt_s.arready = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge SYS_CLK) begin
        if (!RESET_N) begin
            s_ff <= '0;
            s_ff.osc_trim_coarse <= COARSE_RST;
            s_ff.osc_trim_fine <= FINE_RST;
            s_ff.osc_trim_range <= RANGE_RST;
            s_ff.awready <= 1'b1;
            s_ff.wready <= 1'b1;
            s_ff.arready <= 1'b1;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign HIGH_DIV_OUT = s_ff.hp_cnt;
    assign LOW_DIV_OUT = s_ff.lp_cnt;
    assign LOW_DIV_IN = s_ff.lp_lvl;
    assign CORE_SLOW_CLK = s_ff.core_clk;
    assign WARMUP_FLAG = s_ff.crystal_warmup_flag;
    assign S_AXI_AWREADY = s_ff.awready;
    assign S_AXI_WREADY = s_ff.wready;
    assign S_AXI_BVALID = s_ff.bvalid;
    assign S_AXI_BRESP = s_ff.bresp;
    assign S_AXI_ARREADY = s_ff.arready;
    assign S_AXI_RVALID = s_ff.rvalid;
    assign S_AXI_RDATA = s_ff.rdata;
    assign S_AXI_RRESP = s_ff.rresp;

endmodule

// [tb/prescaler_assertions.sv]
`timescale 1ns/1ps
module prescaler_checker
    import prescaler_pkg::*;
#(
    parameter int WARMUP_CYCLES = WARMUP_DEFAULT
) (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RESET_N,
    // Divider outputs
    input wire logic [HIGH_STAGES-1:0] HIGH_DIV_OUT,
    input wire logic [LOW_STAGES-1:0] LOW_DIV_OUT,
    input wire logic LOW_DIV_IN,
    input wire logic WARMUP_FLAG,
    // Bus handshakes
    input wire logic S_AXI_AWVALID,
    input wire logic S_AXI_AWREADY,
    input wire logic S_AXI_WVALID,
    input wire logic S_AXI_WREADY,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [1:0] S_AXI_BRESP,
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic [1:0] S_AXI_RRESP,
    input wire logic [AXI_DW-1:0] S_AXI_RDATA
);
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RESET_N);

    a_chains_reset: assert property ($rose(RESET_N) |-> HIGH_DIV_OUT == '0 && LOW_DIV_OUT == '0)
        else $error("chains not zero after reset");
    a_high_single_step: assert property ($past(RESET_N) && HIGH_DIV_OUT != $past(HIGH_DIV_OUT)
        |-> HIGH_DIV_OUT == $past(HIGH_DIV_OUT) + 8'h1) else $error("high chain jumped");
    a_low_single_step: assert property ($past(RESET_N) && LOW_DIV_OUT != $past(LOW_DIV_OUT)
        |-> LOW_DIV_OUT == $past(LOW_DIV_OUT) + 15'h1 || LOW_DIV_OUT == '0) else $error("low chain jumped");
    a_low_needs_input: assert property ($past(RESET_N) && LOW_DIV_OUT == $past(LOW_DIV_OUT) + 15'h1
        |-> LOW_DIV_IN || $past(LOW_DIV_IN) || $past(LOW_DIV_IN, 2)) else $error("low chain moved without input");
    a_warmup_clears_low: assert property ($rose(WARMUP_FLAG) |-> LOW_DIV_OUT == '0)
        else $error("low chain not cleared by crystal enable");
    a_bresp_held: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
        else $error("write response dropped");
    a_rdata_held: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
        else $error("read data dropped");
    a_write_answer: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
        |-> ##[1:2] S_AXI_BVALID) else $error("write response late");
    a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && !S_AXI_ARREADY)
        else $error("read response late");
    a_write_release: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID && S_AXI_AWREADY && S_AXI_WREADY)
        else $error("write channel not released");
    a_read_release: assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID && S_AXI_ARREADY)
        else $error("read channel not released");

    c_warmup_done: cover property ($fell(WARMUP_FLAG));
    c_read_error: cover property (S_AXI_RVALID && S_AXI_RREADY && S_AXI_RRESP == RESP_SLVERR);
    c_write_done: cover property (S_AXI_BVALID && S_AXI_BREADY);
endmodule

bind prescaler_32k_tap_select prescaler_checker #(.WARMUP_CYCLES(WARMUP_CYCLES)) u_prescaler_checker (
    .SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .HIGH_DIV_OUT(HIGH_DIV_OUT), .LOW_DIV_OUT(LOW_DIV_OUT),
    .LOW_DIV_IN(LOW_DIV_IN), .WARMUP_FLAG(WARMUP_FLAG), .S_AXI_AWVALID(S_AXI_AWVALID),
    .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
    .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_BRESP(S_AXI_BRESP),
    .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RVALID(S_AXI_RVALID),
    .S_AXI_RREADY(S_AXI_RREADY), .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RDATA(S_AXI_RDATA));

// [tb/tb.sv]
`timescale 1ns/1ps
module tb
    import prescaler_pkg::*;
;
    localparam int WARM = 8;
    logic SYS_CLK, RESET_N, RC_CLK, XTAL_CLK, EXT_CLK, LOW_DIV_IN, CORE_SLOW_CLK, WARMUP_FLAG;
    logic [HIGH_STAGES-1:0] HIGH_DIV_OUT, hs;
    logic [LOW_STAGES-1:0] LOW_DIV_OUT, ex;
    logic [AXI_AW-1:0] S_AXI_AWADDR, S_AXI_ARADDR;
    logic [AXI_DW-1:0] S_AXI_WDATA, S_AXI_RDATA;
    logic [3:0] S_AXI_WSTRB;
    logic S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID, S_AXI_BREADY;
    logic S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY;
    logic [1:0] S_AXI_BRESP, S_AXI_RRESP, ph;
    logic [2:0] osc_en;
    logic xs, in_tol;
    int failures, checked;
    logic [5:0] fine_t [11] = '{6'h20, 6'h00, 6'h28, 6'h00, 6'h3F, 6'h28, 6'h0F, 6'h38, 6'h38, 6'h00, 6'h3F};
    logic [4:0] trim_b_t [11] = '{5'h00, 5'h01, 5'h01, 5'h02, 5'h02, 5'h03, 5'h04, 5'h05, 5'h0B, 5'h12, 5'h1F};
    int k_t [11] = '{0, 1, 2, 1, 3, 3, 2, 4, 5, 5, 7};

    prescaler_32k_tap_select #(.WARMUP_CYCLES(WARM)) u_prescaler_32k_tap_select (
        .SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .RC_CLK(RC_CLK), .XTAL_CLK(XTAL_CLK), .EXT_CLK(EXT_CLK),
        .HIGH_DIV_OUT(HIGH_DIV_OUT), .LOW_DIV_OUT(LOW_DIV_OUT), .LOW_DIV_IN(LOW_DIV_IN),
        .CORE_SLOW_CLK(CORE_SLOW_CLK), .WARMUP_FLAG(WARMUP_FLAG), .S_AXI_AWADDR(S_AXI_AWADDR),
        .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WDATA(S_AXI_WDATA),
        .S_AXI_WSTRB(S_AXI_WSTRB), .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
        .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
        .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
        .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID),
        .S_AXI_RREADY(S_AXI_RREADY));

    initial begin
        SYS_CLK = 1'b0;
        forever #50 SYS_CLK = ~SYS_CLK;
    end

    // Oscillator levels toggle every fourth cycle, well below half the system rate.
    always @(posedge SYS_CLK) begin
        ph <= ph + 2'h1;
        if (ph == 2'h3) begin
            if (osc_en[0]) RC_CLK <= ~RC_CLK;
            if (osc_en[1]) EXT_CLK <= ~EXT_CLK;
            if (osc_en[2]) XTAL_CLK <= ~XTAL_CLK;
        end
    end

    task automatic results;
        $display("failures=%0d checked=%0d", failures, checked);
        if (failures == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic guard(input int n);
        if (n >= 40) begin
            failures++;
            results();
        end
    endtask

    task automatic run(input int n);
        repeat (n * 8) @(posedge SYS_CLK);
    endtask

    // ----------------------------------------------------------------
    // Bus cycles: ready is raised with the request and left high afterwards.
    // ----------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        S_AXI_AWADDR <= a;
        S_AXI_WDATA <= d;
        S_AXI_AWVALID <= 1'b1;
        S_AXI_WVALID <= 1'b1;
        S_AXI_BREADY <= 1'b1;
        n = 0;
        do begin
            @(posedge SYS_CLK);
            if (S_AXI_AWVALID && S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
            if (S_AXI_WVALID && S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
            n++;
        end while (!S_AXI_BVALID && n < 40);
        guard(n);
        chk(32'(S_AXI_BRESP), 32'(er));
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        S_AXI_ARADDR <= a;
        S_AXI_ARVALID <= 1'b1;
        S_AXI_RREADY <= 1'b1;
        n = 0;
        do begin
            @(posedge SYS_CLK);
            if (S_AXI_ARVALID && S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
            n++;
        end while (!S_AXI_RVALID && n < 40);
        guard(n);
        chk(S_AXI_RDATA, ed);
        chk(32'(S_AXI_RRESP), 32'(er));
    endtask

    initial begin
        {RESET_N, RC_CLK, XTAL_CLK, EXT_CLK, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} = '0;
        {S_AXI_ARVALID, S_AXI_RREADY, S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} = '0;
        S_AXI_WSTRB = 4'hF;
        ph = 2'h0;
        osc_en = 3'h0;
        failures = 0;
        checked = 0;
        repeat (20) @(posedge SYS_CLK);
        RESET_N <= 1'b1;
        @(posedge SYS_CLK);
        rd(SYS_CLOCK_ADDR, 32'h0, RESP_OKAY);
        rd(TRIM_B_ADDR, 32'h1, RESP_OKAY);
        rd(CHAIN_ADDR, 32'h0, RESP_OKAY);
        rd(8'h40, 32'h0, RESP_SLVERR);
        wr(8'h40, 32'hF, RESP_SLVERR);
        S_AXI_WSTRB <= 4'hE;
        wr(TRIM_A_ADDR, 32'h3F, RESP_OKAY);
        S_AXI_WSTRB <= 4'hF;
        rd(TRIM_A_ADDR, 32'h0, RESP_OKAY);
        osc_en <= 3'h1;
        run(16);
        chk(32'(HIGH_DIV_OUT), 32'h0);
        wr(SYS_CLOCK_ADDR, 32'h1, RESP_OKAY);
        @(posedge SYS_CLK);
        hs = HIGH_DIV_OUT;
        run(40);
        chk(32'(HIGH_DIV_OUT - hs), 32'h28);
        osc_en <= 3'h2;
        wr(SYS_CLOCK_ADDR, 32'h2, RESP_OKAY);
        run(2);
        hs = HIGH_DIV_OUT;
        run(40);
        chk(32'(HIGH_DIV_OUT - hs), 32'h14);
        osc_en <= 3'h1;
        wr(SYS_CLOCK_ADDR, 32'h1, RESP_OKAY);
        for (int i = 0; i < 11; i++) begin
            wr(TRIM_A_ADDR, 32'(fine_t[i]), RESP_OKAY);
            wr(TRIM_B_ADDR, 32'(trim_b_t[i]), RESP_OKAY);
            rd(TRIM_B_ADDR, 32'(trim_b_t[i]), RESP_OKAY);
            run(200);
            wr(DIV_CTRL_ADDR, 32'h1, RESP_OKAY);
            ex = 15'(256 >> k_t[i]);
            run(256);
            in_tol = LOW_DIV_OUT + 15'h1 >= ex && LOW_DIV_OUT <= ex + 15'h1;
            chk(32'(in_tol), 32'h1);
        end
        wr(SYS_CLOCK_ADDR, 32'h5, RESP_OKAY);
        chk(32'(WARMUP_FLAG), 32'h1);
        chk(32'(LOW_DIV_OUT), 32'h0);
        rd(DIV_CTRL_ADDR, 32'h2, RESP_OKAY);
        osc_en <= 3'h5;
        run(6);
        chk(32'(WARMUP_FLAG), 32'h1);
        run(4);
        chk(32'(WARMUP_FLAG), 32'h0);
        // The slow tap may stay high for 512 cycles before the source can swap.
        run(70);
        wr(DIV_CTRL_ADDR, 32'h1, RESP_OKAY);
        run(16);
        chk(32'(LOW_DIV_OUT + 15'h1 >= 15'h10 && LOW_DIV_OUT <= 15'h11), 32'h1);
        wr(SYS_CLOCK_ADDR, 32'hD, RESP_OKAY);
        repeat (8) begin
            @(posedge SYS_CLK);
            xs = XTAL_CLK;
            @(posedge SYS_CLK);
            chk(32'(CORE_SLOW_CLK), 32'(xs));
        end
        RESET_N <= 1'b0;
        repeat (2) @(posedge SYS_CLK);
        RESET_N <= 1'b1;
        @(posedge SYS_CLK);
        chk(32'({HIGH_DIV_OUT, LOW_DIV_OUT}), 32'h0);
        chk(32'(CORE_SLOW_CLK), 32'h0);
        rd(SYS_CLOCK_ADDR, 32'h0, RESP_OKAY);
        results();
    end
endmodule
